//--- mac_stream_src.sv
`timescale 1ns/10ps
`default_nettype none
module mac_stream_src (
  input  wire logic       pclk,
  output logic      [7:0] data,
  output logic            ctl
);
  // Idle fill until the first frame
  initial begin
    data = 8'h07;
    ctl  = 1'b1;
  end
  // Preamble, delimiter, frame, then a gap well above the minimum
  task automatic send(input logic [7:0] f[$]);
    repeat (7) begin
      @(posedge pclk);
      data <= 8'h55;
      ctl  <= 1'b0;
    end
    @(posedge pclk);
    data <= 8'hd5;
    foreach (f[i]) begin
      @(posedge pclk);
      data <= f[i];
    end
    @(posedge pclk);
    data <= 8'h07;
    ctl  <= 1'b1;
    repeat (24) @(posedge pclk);
  endtask : send
endmodule : mac_stream_src
`default_nettype wire

//--- ptpu_pkg.sv
`default_nettype none
package ptpu_pkg;
  // Register byte offsets
  localparam logic [7:0] IFC_OFF     = 8'h00;
  localparam logic [7:0] ENG0_OFF    = 8'h04;
  localparam logic [7:0] ENG1_OFF    = 8'h08;
  localparam logic [7:0] ENG2_OFF    = 8'h0c;
  localparam logic [7:0] PRE_NS_OFF  = 8'h10;
  localparam logic [7:0] PRE_SEC_OFF = 8'h14;
  localparam logic [7:0] SAV_NS_OFF  = 8'h18;
  localparam logic [7:0] SAV_SEC_OFF = 8'h1c;
  localparam logic [7:0] ADJ_OFF     = 8'h20;
  localparam logic [7:0] PPM_OFF     = 8'h24;
  localparam logic [7:0] PPS_W_OFF   = 8'h28;
  localparam logic [7:0] LAT_OFF     = 8'h2c;
  localparam logic [7:0] FIFO_TS_OFF = 8'h30;
  localparam logic [7:0] FIFO_ID_OFF = 8'h34;
  localparam logic [7:0] STAT_OFF    = 8'h38;
  localparam logic [7:0] TIME_NS_OFF = 8'h3c;
  // interface_control_reg fields
  localparam int BYPASS_BIT         = 0;
  localparam int SPLIT_BYPASS_BIT   = 1;
  localparam int RX_PATH_BYPASS_BIT = 2;
  localparam int TX_PATH_BYPASS_BIT = 3;
  localparam int LOAD_MODE_BIT      = 4;
  localparam int CKS_OFF_LSB        = 16;
  localparam int CKS_MODE_LSB       = 24;
  localparam logic [31:0] IFC_RST   = 32'h0000_0001;
  // Engine config fields: [15:0] type, [22:16] stamp offset, [31] enable
  localparam int ENG_OFF_LSB = 16;
  localparam int ENG_EN_BIT  = 31;
  localparam int ENGINES     = 3;
  // Checksum modes
  localparam logic [1:0] CKS_ZERO   = 2'h1;
  localparam logic [1:0] CKS_ADJUST = 2'h2;
  // Stream codes
  localparam logic [7:0]  PRE_BYTE   = 8'h55;
  localparam logic [7:0]  SFD_BYTE   = 8'hd5;
  localparam logic [7:0]  IDLE_BYTE  = 8'h07;
  localparam logic [15:0] PAUSE_TYPE = 16'h8808;
  localparam logic [10:0] TYPE_POS   = 11'd12;
  localparam logic [10:0] DEC_POS    = 11'd14;
  localparam logic [31:0] CRC_POLY   = 32'hedb88320;
  // Pipeline and FIFO sizes
  localparam int DLY        = 24;
  localparam int FIFO_DEPTH = 8;
  // Timing
  localparam int          CLK_PERIOD_NS = 5;
  localparam logic [31:0] NS_PER_SEC    = 32'd1000000000;
  localparam logic [31:0] PPS_W_RST     = 32'd1000;
endpackage : ptpu_pkg
`default_nettype wire

//--- stamp_update_unit.sv
// Contract
// - Unmatched frames, gap, preamble and delimiter leave unchanged.
// - No byte is ever added or removed; lengths are preserved.
// - Up to three encapsulation engines detect and update frames.
// - Receive frames that match get their ingress time written in.
// - Transmit frames that match get correction or timestamp fields rewritten.
// - Both directions identical except the egress-only timestamp FIFO; the code also subtracts latency on receive and adds it on send.
// - FIFO entries hold the timestamp plus a unique frame tag; CPU reads.
// - Both directions run on the one data path clock, pclk.
// - Load/save pin loads preset time or saves current time, per config.
// - Once-per-second pulse with programmable width.
// - SOF detector feeds both delay line and analyzer.
// - Delay line lasts until decisions are ready at the rewriter.
// - Timestamp captured at detected SOF and formed for insertion.
// - Rewriter zeroes UDP checksum or adjusts content to keep it valid.
// - Rewriter recomputes the FCS after modifying a frame.
// - Bypass changes only while idle fills the bypass stage.
// - Split bypass gives per-direction bypass bits, else one common bit.
// - Pause frames pass unmodified.
// - Both analyzers share one configuration set.
// - PCS latency compensation applied to timestamps.
// - Software steps time by plus or minus one nanosecond per write.
// - Programmed clock count per one-nanosecond correction absorbs PPM.
// - No engine match means no modification; timestamp discarded.
`timescale 1ns/10ps
`default_nettype none
module stamp_update_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  rx_in_data,
  input  wire logic        rx_in_ctl,
  output logic      [7:0]  rx_out_data,
  output logic             rx_out_ctl,
  input  wire logic [7:0]  tx_in_data,
  input  wire logic        tx_in_ctl,
  output logic      [7:0]  tx_out_data,
  output logic             tx_out_ctl,
  input  wire logic        load_save,
  output logic             pps_out
);
  localparam int D = ptpu_pkg::DLY;
  localparam int F = ptpu_pkg::FIFO_DEPTH;

  typedef struct packed {
    logic [D-1:0][9:0] dly;
    logic              in_fr;
    logic [10:0]       pos_i;
    logic [15:0]       etype;
    logic              hit;
    logic              mult;
    logic              push;
    logic [1:0]        eng;
    logic [6:0]        off;
    logic [61:0]       ts;
    logic [10:0]       len;
    logic              out_fr;
    logic [10:0]       pos_o;
    logic              act;
    logic [6:0]        aoff;
    logic [63:0]       ats;
    logic [31:0]       crc;
    logic [15:0]       acc;
    logic [7:0]        lo;
    logic              byp;
    logic [5:0]        idle_cnt;
    logic [8:0]        out;
  } dir_t;

  typedef struct packed {
    dir_t [1:0]         d;
    logic [29:0]        ns;
    logic [31:0]        sec;
    logic [31:0]        ppm_cnt;
    logic [31:0]        pps_cnt;
    logic               pps;
    logic               ls_s1;
    logic               ls_s2;
    logic               ls_q;
    logic [31:0]        interface_control_reg;
    logic [2:0][31:0]   eng_cfg;
    logic [29:0]        pre_ns;
    logic [31:0]        pre_sec;
    logic [29:0]        sav_ns;
    logic [31:0]        sav_sec;
    logic [1:0]         adj;
    logic [31:0]        ppm_cfg;
    logic [31:0]        pps_w;
    logic [29:0]        lat;
    logic [F-1:0][39:0] fifo;
    logic [2:0]         wp;
    logic [2:0]         rp;
    logic [3:0]         cnt;
    logic [7:0]         seq;
    logic               ovf;
    logic               mult_st;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } st_t;

  st_t st_r;
  st_t st_nxt;
  logic [61:0] tsv [2];

  // One byte of reflected CRC-32
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ ptpu_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc8

  // Ones-complement 16-bit add
  function automatic logic [15:0] oadd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0, s[16]};
  endfunction : oadd

  // Time plus or minus compensation, wrapping the seconds
  function automatic logic [61:0] comp(input logic [31:0] s, input logic [29:0] n,
                                       input logic [29:0] l, input logic sub);
    logic [31:0] t;
    logic [31:0] sc;
    sc = s;
    if (sub) begin
      t = {2'b0, n} - {2'b0, l};
      if ({2'b0, n} < {2'b0, l}) begin
        t = t + ptpu_pkg::NS_PER_SEC;
        sc = s - 32'h1;
      end
    end else begin
      t = {2'b0, n} + {2'b0, l};
      if (t >= ptpu_pkg::NS_PER_SEC) begin
        t = t - ptpu_pkg::NS_PER_SEC;
        sc = s + 32'h1;
      end
    end
    return {sc, t[29:0]};
  endfunction : comp

  // One direction of the unit; both directions use this same step
  function automatic dir_t step(input dir_t c, input logic ctl, input logic [7:0] dat,
                                input logic byp_req, input logic [31:0] ifc,
                                input logic [2:0][31:0] ecfg, input logic [61:0] tv);
    dir_t        n;
    logic        sof;
    logic [2:0]  m;
    logic [9:0]  o;
    logic [7:0]  nb;
    logic [10:0] p;
    logic [6:0]  rel;
    logic [6:0]  coff;
    logic [15:0] s;
    logic [11:0] fpos;
    n = c;
    n.push = 1'b0;
    n.mult = 1'b0;
    coff = ifc[ptpu_pkg::CKS_OFF_LSB +: 7];
    // SOF detect ahead of the delay line and the analyzer
    sof = !ctl && dat == ptpu_pkg::SFD_BYTE && !c.in_fr &&
          c.dly[0][8:0] == {1'b0, ptpu_pkg::PRE_BYTE};
    n.dly = {c.dly[D-2:0], {sof, ctl, dat}};
    if (sof) begin
      n.in_fr = 1'b1;
      n.pos_i = 11'h0;
      n.ts = tv;
    end else if (c.in_fr && ctl) begin
      n.in_fr = 1'b0;
      n.len = c.pos_i;
    end else if (c.in_fr) begin
      n.pos_i = c.pos_i + 11'h1;
      if (c.pos_i == ptpu_pkg::TYPE_POS) n.etype[15:8] = dat;
      if (c.pos_i == ptpu_pkg::TYPE_POS + 11'h1) n.etype[7:0] = dat;
      // Engine compare; shared config for both analyzers
      if (c.pos_i == ptpu_pkg::DEC_POS) begin
        for (int e = 0; e < ptpu_pkg::ENGINES; e++) begin
          m[e] = ecfg[e][ptpu_pkg::ENG_EN_BIT] && ecfg[e][15:0] == c.etype &&
                 c.etype != ptpu_pkg::PAUSE_TYPE;
        end
        n.hit = m == 3'b001 || m == 3'b010 || m == 3'b100;
        n.mult = !n.hit && m != 3'b000;
        n.eng = m[2] ? 2'd2 : (m[1] ? 2'd1 : 2'd0);
        n.off = ecfg[n.eng][ptpu_pkg::ENG_OFF_LSB +: 7];
        n.push = n.hit;
      end
    end
    // Rewriter at the delay line tail
    o = c.dly[D-1];
    nb = o[7:0];
    p = c.pos_o;
    rel = p[6:0] - c.aoff;
    fpos = {1'b0, p} + 12'd4;
    if (o[9]) begin
      n.out_fr = 1'b1;
      n.pos_o = 11'h0;
      n.act = c.hit;
      n.aoff = c.off;
      n.ats = {c.ts[61:30], 2'b00, c.ts[29:0]};
      n.crc = 32'hffff_ffff;
      n.acc = 16'h0;
      n.len = 11'h7ff;
    end else if (c.out_fr && o[8]) begin
      n.out_fr = 1'b0;
    end else if (c.out_fr) begin
      n.pos_o = p + 11'h1;
      if (c.act) begin
        // Stamp insertion, either direction
        if (p[10:7] == 4'h0 && p[6:0] >= c.aoff && rel < 7'd8) begin
          nb = c.ats[63 - 8 * rel[2:0] -: 8];
          s = rel[0] ? oadd(oadd(c.acc, {8'h00, o[7:0]}), {8'hff, ~nb}) :
                       oadd(oadd(c.acc, {o[7:0], 8'h00}), {~nb, 8'hff});
          n.acc = s;
        end
        // UDP checksum: zero it or fold the stamp difference into the checksum bytes at its offset
        if (ifc[ptpu_pkg::CKS_MODE_LSB +: 2] == ptpu_pkg::CKS_ZERO && p[10:7] == 4'h0 &&
            (p[6:0] == coff || p[6:0] == coff + 7'h1)) begin
          nb = 8'h00;
        end
        if (ifc[ptpu_pkg::CKS_MODE_LSB +: 2] == ptpu_pkg::CKS_ADJUST && p[10:7] == 4'h0) begin
          if (p[6:0] == coff) begin
            s = oadd({o[7:0], c.dly[D-2][7:0]}, c.acc);
            nb = s[15:8];
            n.lo = s[7:0];
          end else if (p[6:0] == coff + 7'h1) begin
            nb = c.lo;
          end
        end
        // New FCS over the modified bytes
        if (fpos >= {1'b0, c.len}) begin
          nb = ~c.crc[8 * fpos[1:0] +: 8];
        end else begin
          n.crc = crc8(c.crc, nb);
        end
      end
    end
    // Bypass switch waits for a delay line full of idle
    if (ctl && dat == ptpu_pkg::IDLE_BYTE) begin
      n.idle_cnt = (c.idle_cnt == 6'(D)) ? c.idle_cnt : c.idle_cnt + 6'h1;
    end else begin
      n.idle_cnt = 6'h0;
    end
    if (c.idle_cnt == 6'(D) && ctl && dat == ptpu_pkg::IDLE_BYTE) begin
      n.byp = byp_req;
    end
    n.out = c.byp ? {ctl, dat} : {o[8], nb};
    return n;
  endfunction : step

  // Stamp values with latency compensation: minus on receive, plus on send
  always_comb begin
    tsv[0] = comp(st_r.sec, st_r.ns, st_r.lat, 1'b1);
    tsv[1] = comp(st_r.sec, st_r.ns, st_r.lat, 1'b0);
  end

  // Whole next state
  always_comb begin
    logic        bg;
    logic        rx_req;
    logic        tx_req;
    logic        ls_edge;
    logic        ppm_hit;
    logic        inc;
    logic        dec;
    logic [31:0] t;
    logic        acc_ph;
    logic        setup;
    logic        pop;
    logic        push;
    logic [31:0] ifc;
    bg = 1'b0;
    rx_req = 1'b0;
    tx_req = 1'b0;
    ls_edge = 1'b0;
    ppm_hit = 1'b0;
    inc = 1'b0;
    dec = 1'b0;
    t = 32'h0;
    pop = 1'b0;
    push = 1'b0;
    st_nxt = st_r;
    ifc = st_r.interface_control_reg;
    setup = psel && !penable;
    acc_ph = psel && penable && st_r.pready;
    // Per-direction bypass request
    bg = ifc[ptpu_pkg::BYPASS_BIT];
    rx_req = ifc[ptpu_pkg::SPLIT_BYPASS_BIT] ? ifc[ptpu_pkg::RX_PATH_BYPASS_BIT] : bg;
    tx_req = ifc[ptpu_pkg::SPLIT_BYPASS_BIT] ? ifc[ptpu_pkg::TX_PATH_BYPASS_BIT] : bg;
    // Both directions clocked by the data path clock
    st_nxt.d[0] = step(st_r.d[0], rx_in_ctl, rx_in_data, rx_req, ifc,
                       st_r.eng_cfg, tsv[0]);
    st_nxt.d[1] = step(st_r.d[1], tx_in_ctl, tx_in_data, tx_req, ifc,
                       st_r.eng_cfg, tsv[1]);
    // Load/save pin through two flops, rising edge acts
    st_nxt.ls_s1 = load_save;
    st_nxt.ls_s2 = st_r.ls_s1;
    st_nxt.ls_q = st_r.ls_s2;
    ls_edge = st_r.ls_s2 && !st_r.ls_q;
    // PPM correction every programmed number of clocks
    if (st_r.ppm_cfg[30:0] != 31'h0) begin
      ppm_hit = st_r.ppm_cnt >= {1'b0, st_r.ppm_cfg[30:0]} - 32'h1;
      st_nxt.ppm_cnt = ppm_hit ? 32'h0 : st_r.ppm_cnt + 32'h1;
    end
    inc = st_r.adj[0] || (ppm_hit && !st_r.ppm_cfg[31]);
    dec = st_r.adj[1] || (ppm_hit && st_r.ppm_cfg[31]);
    st_nxt.adj = 2'b00;
    t = {2'b0, st_r.ns} + 32'(ptpu_pkg::CLK_PERIOD_NS) + {31'h0, inc} - {31'h0, dec};
    st_nxt.pps = st_r.pps_cnt != 32'h0;
    st_nxt.pps_cnt = (st_r.pps_cnt != 32'h0) ? st_r.pps_cnt - 32'h1 : 32'h0;
    if (t >= ptpu_pkg::NS_PER_SEC) begin
      t = t - ptpu_pkg::NS_PER_SEC;
      st_nxt.sec = st_r.sec + 32'h1;
      st_nxt.pps_cnt = st_r.pps_w;
    end
    st_nxt.ns = t[29:0];
    if (ls_edge && ifc[ptpu_pkg::LOAD_MODE_BIT]) begin
      st_nxt.ns = st_r.pre_ns;
      st_nxt.sec = st_r.pre_sec;
    end else if (ls_edge) begin
      st_nxt.sav_ns = st_r.ns;
      st_nxt.sav_sec = st_r.sec;
    end
    // APB read data and answer at setup, effects at access
    st_nxt.pready = setup;
    st_nxt.pslverr = 1'b0;
    if (setup) begin
      st_nxt.pslverr = paddr[1:0] != 2'b00 || paddr > ptpu_pkg::TIME_NS_OFF;
      case (paddr)
        ptpu_pkg::IFC_OFF:     st_nxt.prdata = ifc;
        ptpu_pkg::ENG0_OFF:    st_nxt.prdata = st_r.eng_cfg[0];
        ptpu_pkg::ENG1_OFF:    st_nxt.prdata = st_r.eng_cfg[1];
        ptpu_pkg::ENG2_OFF:    st_nxt.prdata = st_r.eng_cfg[2];
        ptpu_pkg::PRE_NS_OFF:  st_nxt.prdata = {2'b0, st_r.pre_ns};
        ptpu_pkg::PRE_SEC_OFF: st_nxt.prdata = st_r.pre_sec;
        ptpu_pkg::SAV_NS_OFF:  st_nxt.prdata = {2'b0, st_r.sav_ns};
        ptpu_pkg::SAV_SEC_OFF: st_nxt.prdata = st_r.sav_sec;
        ptpu_pkg::PPM_OFF:     st_nxt.prdata = st_r.ppm_cfg;
        ptpu_pkg::PPS_W_OFF:   st_nxt.prdata = st_r.pps_w;
        ptpu_pkg::LAT_OFF:     st_nxt.prdata = {2'b0, st_r.lat};
        ptpu_pkg::FIFO_TS_OFF: st_nxt.prdata = {2'b0, st_r.fifo[st_r.rp][29:0]};
        ptpu_pkg::FIFO_ID_OFF: st_nxt.prdata = {22'h0, st_r.fifo[st_r.rp][39:30]};
        ptpu_pkg::STAT_OFF:    st_nxt.prdata = {26'h0, st_r.mult_st, st_r.ovf, st_r.cnt};
        ptpu_pkg::TIME_NS_OFF: st_nxt.prdata = {2'b0, st_r.ns};
        default:               st_nxt.prdata = 32'h0;
      endcase
    end
    if (acc_ph && pwrite) begin
      case (paddr)
        ptpu_pkg::IFC_OFF:     st_nxt.interface_control_reg = pwdata;
        ptpu_pkg::ENG0_OFF:    st_nxt.eng_cfg[0] = pwdata;
        ptpu_pkg::ENG1_OFF:    st_nxt.eng_cfg[1] = pwdata;
        ptpu_pkg::ENG2_OFF:    st_nxt.eng_cfg[2] = pwdata;
        ptpu_pkg::PRE_NS_OFF:  st_nxt.pre_ns = pwdata[29:0];
        ptpu_pkg::PRE_SEC_OFF: st_nxt.pre_sec = pwdata;
        ptpu_pkg::ADJ_OFF:     st_nxt.adj = pwdata[1:0];
        ptpu_pkg::PPM_OFF:     st_nxt.ppm_cfg = pwdata;
        ptpu_pkg::PPS_W_OFF:   st_nxt.pps_w = pwdata;
        ptpu_pkg::LAT_OFF:     st_nxt.lat = pwdata[29:0];
        ptpu_pkg::STAT_OFF: begin
          st_nxt.ovf = st_r.ovf && !pwdata[4];
          st_nxt.mult_st = st_r.mult_st && !pwdata[5];
        end
        default: ;
      endcase
    end
    // Egress FIFO: pop on ID read, refuse push when full and not popping
    pop = acc_ph && !pwrite && paddr == ptpu_pkg::FIFO_ID_OFF && st_r.cnt != 4'h0;
    if (st_r.d[1].push) begin
      st_nxt.seq = st_r.seq + 8'h1;
      push = st_r.cnt != 4'(F) || pop;
      if (!push) st_nxt.ovf = 1'b1;
    end
    if (push) begin
      st_nxt.fifo[st_r.wp] = {st_r.seq, st_r.d[1].eng, st_r.d[1].ts[29:0]};
      st_nxt.wp = st_r.wp + 3'h1;
    end
    if (pop) st_nxt.rp = st_r.rp + 3'h1;
    st_nxt.cnt = st_r.cnt + {3'h0, push} - {3'h0, pop};
    // Sticky: set wins over clear
    if (st_r.d[0].mult || st_r.d[1].mult) st_nxt.mult_st = 1'b1;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.interface_control_reg <= ptpu_pkg::IFC_RST;
      st_r.pps_w <= ptpu_pkg::PPS_W_RST;
      st_r.d[0].byp <= 1'b1;
      st_r.d[1].byp <= 1'b1;
      st_r.d[0].out <= {1'b1, ptpu_pkg::IDLE_BYTE};
      st_r.d[1].out <= {1'b1, ptpu_pkg::IDLE_BYTE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata      = st_r.prdata;
  assign pready      = st_r.pready;
  assign pslverr     = st_r.pslverr;
  assign rx_out_data = st_r.d[0].out[7:0];
  assign rx_out_ctl  = st_r.d[0].out[8];
  assign tx_out_data = st_r.d[1].out[7:0];
  assign tx_out_ctl  = st_r.d[1].out[8];
  assign pps_out     = st_r.pps;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_len_keep: assert property (!st_r.d[0].byp && !$past(st_r.d[0].byp, D + 1)
    |-> rx_out_ctl == $past(rx_in_ctl, D + 1)) else $error("length changed");
  a_pass_thru: assert property (!st_r.d[1].byp && !$past(st_r.d[1].byp, D + 1) &&
    !$past(st_r.d[1].act) |-> tx_out_data == $past(tx_in_data, D + 1))
    else $error("unmatched byte altered");
  a_bypass_idle: assert property ($changed(st_r.d[0].byp)
    |-> $past(rx_in_ctl) && $past(rx_in_data) == ptpu_pkg::IDLE_BYTE)
    else $error("bypass switched mid frame");
  a_fifo_bound: assert property (st_r.cnt <= 4'(F)) else $error("fifo count over depth");
  a_load_time: assert property (st_r.ls_s2 && !st_r.ls_q &&
    st_r.interface_control_reg[ptpu_pkg::LOAD_MODE_BIT] |=> st_r.ns == $past(st_r.pre_ns))
    else $error("preset not loaded");
  a_save_time: assert property (st_r.ls_s2 && !st_r.ls_q &&
    !st_r.interface_control_reg[ptpu_pkg::LOAD_MODE_BIT] |=> st_r.sav_ns == $past(st_r.ns))
    else $error("time not saved");
  a_pps_width: assert property ($rose(pps_out)
    |-> st_r.pps_cnt == st_r.pps_w - 32'h1) else $error("pulse width wrong");
  a_adj_step: assert property (st_r.adj == 2'b01 && st_r.ppm_cfg == 32'h0 &&
    st_r.ns < 30'd999000000 && !(st_r.ls_s2 && !st_r.ls_q)
    |=> st_r.ns == $past(st_r.ns) + 30'd6) else $error("plus step wrong");
  a_pause_nop: assert property (st_r.d[0].in_fr &&
    st_r.d[0].pos_i == ptpu_pkg::DEC_POS && st_r.d[0].etype == ptpu_pkg::PAUSE_TYPE
    |=> !st_r.d[0].hit) else $error("pause frame matched");
  a_ts_capture: assert property (st_r.d[0].dly[0][9]
    |-> st_r.d[0].ts == $past(tsv[0])) else $error("stamp not captured at sof");
  c_rx_stamp: cover property (st_r.d[0].act && st_r.d[0].out_fr);
  c_tx_push: cover property (st_r.d[1].push);
  c_fifo_full: cover property (st_r.cnt == 4'(F));
  c_bypass_off: cover property ($fell(st_r.d[1].byp));
endmodule : stamp_update_unit
`default_nettype wire

//--- stamp_update_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module stamp_update_unit_tb;
  typedef logic [7:0] bq_t[$];
  logic        pclk, presetn, psel, penable, pwrite, load_save, pready, pslverr, er;
  logic        rx_in_ctl, tx_in_ctl, rx_out_ctl, tx_out_ctl, pps_out;
  logic [7:0]  paddr, rx_in_data, tx_in_data, rx_out_data, tx_out_data;
  logic [31:0] pwdata, prdata, seed, rd;
  logic [31:0] tm [4];
  int          miscompares, num_checks, n;
  bq_t         rxq, txq;
  stamp_update_unit i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_in_data(rx_in_data), .rx_in_ctl(rx_in_ctl), .rx_out_data(rx_out_data),
    .rx_out_ctl(rx_out_ctl), .tx_in_data(tx_in_data), .tx_in_ctl(tx_in_ctl),
    .tx_out_data(tx_out_data), .tx_out_ctl(tx_out_ctl), .load_save(load_save),
    .pps_out(pps_out));
  mac_stream_src i_rxs (.pclk(pclk), .data(rx_in_data), .ctl(rx_in_ctl));
  mac_stream_src i_txs (.pclk(pclk), .data(tx_in_data), .ctl(tx_in_ctl));
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Collect frame bytes leaving each direction
  always @(posedge pclk) begin
    if (rx_out_ctl === 1'b0) rxq.push_back(rx_out_data);
    if (tx_out_ctl === 1'b0) txq.push_back(tx_out_data);
  end
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  // Reflected CRC, written apart from the design's own
  function automatic logic [31:0] crc(input bq_t q);
    logic [31:0] c;
    c = 32'hffffffff;
    foreach (q[i]) begin
      c ^= {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction : crc
  // Minimum-size frame of random bytes with a valid check sequence
  function automatic bq_t mk(input logic [15:0] ty);
    bq_t         q;
    logic [31:0] c;
    for (int i = 0; i < 60; i++) q.push_back(i == 12 ? ty[15:8] : i == 13 ? ty[7:0] : rnd());
    c = crc(q);
    return {q, c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction : mk
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // One transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    chk("pready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Stamp bytes and check sequence are left to the CRC test
  task automatic cmpf(input string nm, input bq_t g, input bq_t x, input int so);
    chk(nm, x.size() + 8, g.size());
    if (g.size() == x.size() + 8) begin
      for (int i = 0; i < g.size(); i++)
        if (so < 0 || i < 8 || (i < so + 8 || i >= so + 16) && i < 68)
          chk(nm, i < 7 ? 8'h55 : i == 7 ? 8'hd5 : x[i - 8], g[i]);
      chk(nm, crc(g[8:67]), {g[71], g[70], g[69], g[68]});
    end
  endtask : cmpf
  // One frame each way; waits out the delay line before checking
  task automatic xfer(input logic [15:0] ty, input int so);
    bq_t a, b;
    a = mk(ty);
    b = mk(ty);
    rxq.delete();
    txq.delete();
    fork
      i_rxs.send(a);
      i_txs.send(b);
    join
    repeat (20) @(posedge pclk);
    cmpf("rx", rxq, a, so);
    cmpf("tx", txq, b, so);
  endtask : xfer
  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // Generous bound on the whole sequence
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    complete_run();
  end
  // Main sequence
  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    load_save = 1'b0;
    seed      = 32'he4e68adf;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ptpu_pkg::IFC_OFF, 0);
    chk("ifc", ptpu_pkg::IFC_RST, rd);
    for (int i = 0; i < 2; i++) begin
      apb(0, i ? 8'h40 : 8'h02, 0);
      chk("slverr", 1, er);
    end
    xfer(16'h88f7, -1);
    apb(1, ptpu_pkg::ENG0_OFF, {1'b1, 8'h00, 7'd20, 16'h88f7});
    apb(1, ptpu_pkg::ENG1_OFF, {1'b1, 8'h00, 7'd30, 16'h8902});
    apb(1, ptpu_pkg::ENG2_OFF, {1'b1, 8'h00, 7'd20, ptpu_pkg::PAUSE_TYPE});
    // Leaving bypass in mid-frame must not corrupt it
    fork
      xfer(16'h0800, -1);
      apb(1, ptpu_pkg::IFC_OFF, 0);
    join
    xfer(ptpu_pkg::PAUSE_TYPE, -1);
    apb(1, ptpu_pkg::LAT_OFF, 3);
    for (int e = 0; e < 2; e++) begin
      n = e ? 30 : 20;
      apb(0, ptpu_pkg::TIME_NS_OFF, 0);
      tm[0] = rd;
      xfer(e ? 16'h8902 : 16'h88f7, n);
      apb(0, ptpu_pkg::STAT_OFF, 0);
      chk("count", 1, rd);
      apb(0, ptpu_pkg::FIFO_TS_OFF, 0);
      chk("ns", {2'b00, txq[n + 12][5:0], txq[n + 13], txq[n + 14], txq[n + 15]}, rd);
      // Receive stamp lies twice the compensation below the send stamp
      chk("rx ns", rd - 32'd6, {rxq[n + 12], rxq[n + 13], rxq[n + 14], rxq[n + 15]});
      chk("when", 1, rd - tm[0] < 500);
      apb(0, ptpu_pkg::FIFO_ID_OFF, 0);
      chk("eng", e, rd[1:0]);
      chk("seq", e, rd[9:2]);
    end
    apb(1, ptpu_pkg::ENG1_OFF, {1'b1, 8'h00, 7'd30, 16'h88f7});
    xfer(16'h88f7, -1);
    apb(0, ptpu_pkg::STAT_OFF, 0);
    chk("multi", 32'h20, rd);
    apb(1, ptpu_pkg::STAT_OFF, 32'h20);
    apb(1, ptpu_pkg::ENG1_OFF, 0);
    repeat (9) xfer(16'h88f7, 20);
    apb(0, ptpu_pkg::STAT_OFF, 0);
    chk("full", 32'h18, rd);
    // Trim: one +1 ns write, then one extra ns every four clocks
    for (int i = 0; i < 4; i++) begin
      if (i == 1) apb(1, ptpu_pkg::ADJ_OFF, 1);
      if (i == 2) apb(1, ptpu_pkg::PPM_OFF, 4);
      apb(0, ptpu_pkg::TIME_NS_OFF, 0);
      tm[i] = rd;
      if (i == 2) repeat (41) @(posedge pclk);
    end
    chk("adj", 6 * ptpu_pkg::CLK_PERIOD_NS + 1, tm[1] - tm[0]);
    chk("ppm", 44 * ptpu_pkg::CLK_PERIOD_NS + 11, tm[3] - tm[2]);
    // Load a time just short of a second, then count the pulse
    apb(1, ptpu_pkg::PPS_W_OFF, 10);
    apb(1, ptpu_pkg::PRE_NS_OFF, 999999800);
    apb(1, ptpu_pkg::IFC_OFF, 32'h10);
    load_save <= 1'b1;
    repeat (4) @(posedge pclk);
    load_save <= 1'b0;
    apb(0, ptpu_pkg::TIME_NS_OFF, 0);
    chk("load", 1, rd - 999999800 < 100);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      n += pps_out;
    end
    chk("pps", 10, n);
    complete_run();
  end
endmodule : stamp_update_unit_tb
`default_nettype wire
